//--- hw/tsr_defines.svh
// Purpose: offsets, reset values, field positions and timing counts
// Assumes: byte-wide parallel host port, one transmit clock
// Notes:   definitions only
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH
// ==========================================================
// register offsets
`define TSR_OFS_EN1       8'h08
`define TSR_OFS_EN2       8'h09
`define TSR_OFS_EN3       8'h0a
`define TSR_OFS_EN4       8'h0b
`define TSR_OFS_SIG_FIRST 8'h50
`define TSR_OFS_SIG_T1END 8'h5b
`define TSR_OFS_SIG_LAST  8'h5f
// ==========================================================
// reset values and fields
`define TSR_EN_RST        8'h00
`define TSR_SIG_RST       8'h00
`define TSR_ALIGN_BIT     0
`define TSR_T1_BYTES      12
// ==========================================================
// timing
`define TSR_CLK_MHZ       50
`define TSR_D4_WRITE_US   120
`define TSR_D4_WIN_CYC    (`TSR_D4_WRITE_US * `TSR_CLK_MHZ)
`endif

//--- hw/tsr_pkg.sv
// Purpose: types shared by the transmit signaling bank
// Assumes: nothing beyond the defines header
// Notes:   types only
package tsr_pkg;
  // ==========================================================
  // signaling layouts
  typedef enum logic [1:0] {
    TSR_E1_CCS,
    TSR_E1_CAS,
    TSR_T1_ESF,
    TSR_T1_D4
  } tsr_mode_e;

  // one host access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tsr_host_s;

  // per-channel lookup answer
  typedef struct packed {
    logic       en;
    logic [3:0] sig;
  } tsr_chan_s;

  // e1 cas alignment/alarm word sourcing
  typedef struct packed {
    logic       upper_cas_align_source;
    logic       lower_cas_align_source;
    logic [3:0] upper;
    logic [3:0] lower;
  } tsr_cas_s;
endpackage

//--- hw/tsr_bank.sv
// Purpose: transmit signaling store with per-channel insertion enables
// Assumes: all inputs synchronous to the transmit clock clk
// Notes:   framer datapath outside; it polls channels via ch_sel
`include "tsr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Contract
// RL1: in E1 CCS the sixteen bytes form 128 serial bits, MSB of byte 1 first.
// RL2: in T1 ESF twelve bytes hold ABCD, even channel high, odd channel low.
// RL3: in T1 D4 each channel nibble holds A,B then a second A,B pair.
// RL4: D4 contents are treated as signaling for two successive frames.
// RL5: in E1 CAS the first byte can supply the alignment/alarm word.
// RL6: bit 0 of enable 1 sources the upper align nibble from byte 1.
// RL7: in E1 CAS bits 1..7 of enable 1 enable channels 1..7.
// RL8: in E1 CAS bits 0..7 of enable 2 enable channels 8..15.
// RL9: bit 0 of enable 3 sources the lower align nibble from byte 1.
// RL10: in E1 CAS bits 1..7 of enable 3 enable channels 16..22.
// RL11: in E1 CAS bits 0..7 of enable 4 enable channels 23..30.
// RL12: an enable bit of 1 inserts from the store, 0 does not; all reset 0.
// RL13: at each multiframe boundary the store is copied to the out register.
// RL14: in D4 the C,D slots give the next multiframe; reload every other one.
// RL15: in D4 the host writes within 120 us of every other boundary.
// RL16: in T1 only the first twelve bytes are used.
module tsr_bank
  import tsr_pkg::*;
#(
  parameter int D4_WIN_CYC = `TSR_D4_WIN_CYC
) (
  input  wire logic      clk,
  input  wire logic      srst,
  input  wire tsr_host_s host,
  output logic [7:0]     rdata,
  input  wire tsr_mode_e mode,
  input  wire logic      mf_boundary,
  input  wire logic [4:0] ch_sel,
  output tsr_chan_s      ch_out,
  output tsr_cas_s       cas_out,
  input  wire logic      ccs_shift,
  output logic           ccs_bit,
  output logic           d4_use_cd,
  output logic           d4_write_window
);

  // ==========================================================
  // host registers
  logic [7:0] sw_sig_insert_en_1;
  logic [7:0] sw_sig_insert_en_2;
  logic [7:0] sw_sig_insert_en_3;
  logic [7:0] sw_sig_insert_en_4;
  logic [7:0] tx_signaling_bytes [16];
  logic [7:0] out_reg [16];
  logic [6:0] ccs_ptr;
  logic       is_t1;
  logic       is_sig_addr;
  logic [3:0] sig_idx;
  logic       load_now;

  assign is_t1       = (mode == TSR_T1_ESF) || (mode == TSR_T1_D4);
  assign is_sig_addr = (host.addr >= `TSR_OFS_SIG_FIRST) &&
                       (host.addr <= `TSR_OFS_SIG_LAST);
  assign sig_idx     = host.addr[3:0];

  // enable registers; all clear at reset
  always_ff @(posedge clk) begin
    if (srst) begin
      sw_sig_insert_en_1 <= `TSR_EN_RST; // RL12
      sw_sig_insert_en_2 <= `TSR_EN_RST; // RL12
      sw_sig_insert_en_3 <= `TSR_EN_RST; // RL12
      sw_sig_insert_en_4 <= `TSR_EN_RST; // RL12
    end else if (host.wr) begin
      unique case (host.addr)
        `TSR_OFS_EN1: sw_sig_insert_en_1 <= host.wdata;
        `TSR_OFS_EN2: sw_sig_insert_en_2 <= host.wdata;
        `TSR_OFS_EN3: sw_sig_insert_en_3 <= host.wdata;
        `TSR_OFS_EN4: sw_sig_insert_en_4 <= host.wdata;
        default: ;
      endcase
    end
  end

  // signaling bytes; writes land here only, never in out_reg
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 16; i++) begin
        tx_signaling_bytes[i] <= `TSR_SIG_RST;
      end
    end else if (host.wr && is_sig_addr) begin
      tx_signaling_bytes[sig_idx] <= host.wdata;
    end
  end

  // registered read; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (host.rd) begin
      if (is_sig_addr) begin
        rdata <= tx_signaling_bytes[sig_idx];
      end else begin
        unique case (host.addr)
          `TSR_OFS_EN1: rdata <= sw_sig_insert_en_1;
          `TSR_OFS_EN2: rdata <= sw_sig_insert_en_2;
          `TSR_OFS_EN3: rdata <= sw_sig_insert_en_3;
          `TSR_OFS_EN4: rdata <= sw_sig_insert_en_4;
          default:      rdata <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // multiframe loading
  // d4: load on one boundary, play C,D slots on the next
  assign load_now = mf_boundary && ((mode != TSR_T1_D4) || d4_use_cd);

  always_ff @(posedge clk) begin
    if (srst) begin
      d4_use_cd <= 1'b1; // first boundary after reset loads
    end else if (mf_boundary) begin
      if (mode == TSR_T1_D4) begin
        d4_use_cd <= !d4_use_cd; // RL14
      end else begin
        d4_use_cd <= 1'b1;
      end
    end
  end

  // copy store to outgoing register; t1 leaves bytes 13..16 idle
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 16; i++) begin
        out_reg[i] <= `TSR_SIG_RST;
      end
    end else if (load_now) begin
      for (int i = 0; i < 16; i++) begin
        if (is_t1 && (i >= `TSR_T1_BYTES)) begin
          out_reg[i] <= 8'h00; // RL16
        end else begin
          out_reg[i] <= tx_signaling_bytes[i]; // RL13
        end
      end
    end
  end

  a_load_copy: assert property (@(posedge clk) disable iff (srst) // RL13
    load_now && !host.wr |=> out_reg[3] == $past(tx_signaling_bytes[3]))
    else $error("store not copied at boundary");

  a_d4_reload: assert property (@(posedge clk) disable iff (srst) // RL14
    mf_boundary && mode == TSR_T1_D4 && !d4_use_cd |=>
      $stable(out_reg[0]))
    else $error("d4 reloaded on an off boundary");

  a_t1_unused: assert property (@(posedge clk) disable iff (srst) // RL16
    load_now && is_t1 |=> out_reg[12] == 8'h00 && out_reg[15] == 8'h00)
    else $error("t1 loaded bytes beyond twelve");

  // ==========================================================
  // d4 host write window: open after a boundary that loaded
  // a simple count; host writes late show no error, only a
  // closed window, so software sees only whether the window is open
  localparam int WIN_W = $clog2(D4_WIN_CYC + 1);
  logic [WIN_W-1:0] win_cnt;

  always_ff @(posedge clk) begin
    if (srst) begin
      win_cnt <= '0;
    end else if (load_now && mode == TSR_T1_D4) begin
      win_cnt <= WIN_W'(D4_WIN_CYC); // RL15
    end else if (win_cnt != '0) begin
      win_cnt <= win_cnt - 1'b1;
    end
  end

  assign d4_write_window = (win_cnt != '0) && (mode == TSR_T1_D4);

  a_d4_window: assert property (@(posedge clk) disable iff (srst) // RL15
    load_now && mode == TSR_T1_D4 ##1 mode == TSR_T1_D4 |->
      d4_write_window)
    else $error("d4 write window not opened");

  // ==========================================================
  // e1 ccs serial order: bit 1 is msb of first byte
  logic [3:0] ccs_byte;
  logic [2:0] ccs_pos;

  assign ccs_byte = ccs_ptr[6:3];
  assign ccs_pos  = 3'd7 - ccs_ptr[2:0];

  always_ff @(posedge clk) begin
    if (srst || mf_boundary) begin
      ccs_ptr <= 7'h00;
    end else if (ccs_shift && mode == TSR_E1_CCS) begin
      ccs_ptr <= ccs_ptr + 7'h01; // RL1
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ccs_bit <= 1'b0;
    end else if (mode == TSR_E1_CCS) begin
      ccs_bit <= out_reg[ccs_byte][ccs_pos]; // RL1
    end else begin
      ccs_bit <= 1'b0;
    end
  end

  a_ccs_first: assert property (@(posedge clk) disable iff (srst) // RL1
    mode == TSR_E1_CCS && ccs_ptr == 7'h00 ##1 mode == TSR_E1_CCS |->
      ccs_bit == $past(out_reg[0][7]))
    else $error("ccs bit 1 not msb of first byte");

  // ==========================================================
  // per-channel enable vectors, channel k+1 at index k
  logic [29:0] e1_en;
  logic [23:0] t1_en;

  assign e1_en = {sw_sig_insert_en_4,          // RL11
                  sw_sig_insert_en_3[7:1],     // RL10
                  sw_sig_insert_en_2,          // RL8
                  sw_sig_insert_en_1[7:1]};    // RL7
  assign t1_en = {sw_sig_insert_en_3,
                  sw_sig_insert_en_2,
                  sw_sig_insert_en_1};

  // ==========================================================
  // channel lookup; e1 cas skips the alignment byte
  logic [3:0] ch_byte;
  logic [7:0] ch_data;
  logic [3:0] ch_nib;
  logic       next_en;
  logic [3:0] next_sig;

  assign ch_byte = is_t1 ? ch_sel[4:1] : 4'(ch_sel[4:1] + 4'h1);
  assign ch_data = out_reg[ch_byte];
  // odd channels low nibble, even channels high
  assign ch_nib  = ch_sel[0] ? ch_data[7:4] : ch_data[3:0]; // RL2

  always_comb begin
    next_en  = 1'b0;
    next_sig = 4'h0;
    unique case (mode)
      TSR_E1_CCS: begin
        next_en  = 1'b0;
        next_sig = 4'h0;
      end
      TSR_E1_CAS: begin
        next_en  = (ch_sel < 5'd30) && e1_en[ch_sel]; // RL12
        next_sig = ch_nib;
      end
      TSR_T1_ESF: begin
        next_en  = (ch_sel < 5'd24) && t1_en[ch_sel]; // RL12
        next_sig = ch_nib; // RL2
      end
      TSR_T1_D4: begin
        next_en  = (ch_sel < 5'd24) && t1_en[ch_sel]; // RL12
        // two frames per load: first A,B then the C,D slots
        next_sig = d4_use_cd ? {ch_nib[1:0], 2'b00} // RL4
                             : {ch_nib[3:2], 2'b00}; // RL3
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ch_out <= '0;
    end else begin
      ch_out.en  <= next_en;
      // disabled channels carry no store data
      ch_out.sig <= next_en ? next_sig : 4'h0; // RL12
    end
  end

  a_ch_off: assert property (@(posedge clk) disable iff (srst) // RL12
    mode == TSR_E1_CAS && ch_sel == 5'd0 && !sw_sig_insert_en_1[1] |=>
      !ch_out.en)
    else $error("channel 1 enabled with bit clear");

  a_cas_ch8: assert property (@(posedge clk) disable iff (srst) // RL8
    mode == TSR_E1_CAS && ch_sel == 5'd7 && sw_sig_insert_en_2[0] |=>
      ch_out.en && ch_out.sig == $past(out_reg[4][7:4]))
    else $error("channel 8 not taken from store");

  a_cas_ch30: assert property (@(posedge clk) disable iff (srst) // RL11
    mode == TSR_E1_CAS && ch_sel == 5'd29 && sw_sig_insert_en_4[7] |=>
      ch_out.en && ch_out.sig == $past(out_reg[15][7:4]))
    else $error("channel 30 not taken from store");

  a_esf_ch24: assert property (@(posedge clk) disable iff (srst) // RL2
    mode == TSR_T1_ESF && ch_sel == 5'd23 && sw_sig_insert_en_3[7] |=>
      ch_out.sig == $past(out_reg[11][7:4]))
    else $error("esf channel 24 wrong nibble");

  a_d4_second: assert property (@(posedge clk) disable iff (srst) // RL4
    mode == TSR_T1_D4 && d4_use_cd && ch_sel == 5'd0 &&
      sw_sig_insert_en_1[0] |=>
      ch_out.sig == {$past(out_reg[0][1:0]), 2'b00})
    else $error("d4 second frame not from c,d slots");

  // ==========================================================
  // e1 cas alignment/alarm word sourcing from the first byte
  always_ff @(posedge clk) begin
    if (srst) begin
      cas_out <= '0;
    end else if (mode == TSR_E1_CAS) begin
      cas_out.upper_cas_align_source <=
        sw_sig_insert_en_1[`TSR_ALIGN_BIT]; // RL6
      cas_out.lower_cas_align_source <=
        sw_sig_insert_en_3[`TSR_ALIGN_BIT]; // RL9
      // nibbles zero when not sourced, so a stale byte never leaks
      cas_out.upper <= sw_sig_insert_en_1[`TSR_ALIGN_BIT] ?
                       out_reg[0][7:4] : 4'h0; // RL5
      cas_out.lower <= sw_sig_insert_en_3[`TSR_ALIGN_BIT] ?
                       out_reg[0][3:0] : 4'h0; // RL5
    end else begin
      cas_out <= '0;
    end
  end

  a_cas_upper: assert property (@(posedge clk) disable iff (srst) // RL6
    mode == TSR_E1_CAS && sw_sig_insert_en_1[0] |=>
      cas_out.upper_cas_align_source &&
      cas_out.upper == $past(out_reg[0][7:4]))
    else $error("upper align nibble not sourced");

  a_cas_lower: assert property (@(posedge clk) disable iff (srst) // RL9
    mode == TSR_E1_CAS && !sw_sig_insert_en_3[0] |=>
      !cas_out.lower_cas_align_source && cas_out.lower == 4'h0)
    else $error("lower align nibble sourced while off");

  a_cas_ch16: assert property (@(posedge clk) disable iff (srst) // RL10
    mode == TSR_E1_CAS && ch_sel == 5'd15 |=>
      ch_out.en == $past(sw_sig_insert_en_3[1]))
    else $error("channel 16 enable mismatch");

  a_cas_ch7: assert property (@(posedge clk) disable iff (srst) // RL7
    mode == TSR_E1_CAS && ch_sel == 5'd6 |=>
      ch_out.en == $past(sw_sig_insert_en_1[7]))
    else $error("channel 7 enable mismatch");

  a_en_reset: assert property (@(posedge clk) // RL12
    srst |=> sw_sig_insert_en_1 == 8'h00 && sw_sig_insert_en_4 == 8'h00)
    else $error("enables not cleared by reset");

endmodule
`default_nettype wire

//--- tb/tsr_bank_tb.sv
// Purpose: self-checking bench for the transmit signaling bank
// Assumes: inputs driven 1 ns after the rising edge of clk
// Notes:   short write window parameter keeps the D4 run brief
`include "tsr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench
  import tsr_pkg::*;
;
  localparam int WIN = 20;
  logic       clk;
  logic       srst;
  tsr_host_s  host;
  logic [7:0] rdata;
  tsr_mode_e  mode;
  logic       mf_boundary;
  logic [4:0] ch_sel;
  tsr_chan_s  ch_out;
  tsr_cas_s   cas_out;
  logic       ccs_shift;
  logic       ccs_bit;
  logic       d4_use_cd;
  logic       d4_write_window;
  int         bad_count;
  int         n_tests;

  tsr_bank #(.D4_WIN_CYC(WIN)) i_dut (
    .clk(clk), .srst(srst), .host(host), .rdata(rdata), .mode(mode),
    .mf_boundary(mf_boundary), .ch_sel(ch_sel), .ch_out(ch_out),
    .cas_out(cas_out), .ccs_shift(ccs_shift), .ccs_bit(ccs_bit),
    .d4_use_cd(d4_use_cd), .d4_write_window(d4_write_window));

  // ==========================================================
  // clock and low-level drivers
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    srst = 1'b1;
    repeat (5) tick();
    srst = 1'b0;
  endtask

  // an idle edge after each access, so back-to-back calls never
  // drop and raise the same strobe within one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.wr = 1'b1; host.addr = a; host.wdata = d;
    tick();
    host.wr = 1'b0;
    tick();
  endtask

  // rdata lands on the edge that takes the read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    host.rd = 1'b1; host.addr = a;
    tick();
    host.rd = 1'b0;
    d = rdata;
    tick();
  endtask

  task automatic boundary();
    mf_boundary = 1'b1;
    tick();
    mf_boundary = 1'b0;
  endtask

  // ==========================================================
  // comparisons
  task automatic chk_byte(input string n, input logic [7:0] e,
                          input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask

  // sig is only meaningful while the channel is enabled
  task automatic chan(input logic [4:0] s, input logic en,
                      input logic [3:0] sig);
    ch_sel = s;
    tick();
    chk_bit("ch_out.en", en, ch_out.en);
    if (en) chk_byte("ch_out.sig", {4'h0, sig}, {4'h0, ch_out.sig});
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [7:0] d;
    do_reset();
    for (int i = 0; i < 4; i++) begin
      rd(8'h08 + 8'(i), d);
      chk_byte("enable reset", `TSR_EN_RST, d);
    end
    wr(8'h20, 8'hff);
    rd(8'h20, d);
    chk_byte("unmapped read", 8'h00, d);
    wr(`TSR_OFS_EN2, 8'h5a);
    rd(`TSR_OFS_EN2, d);
    chk_byte("enable readback", 8'h5a, d);
    wr(`TSR_OFS_SIG_LAST, 8'hc3);
    rd(`TSR_OFS_SIG_LAST, d);
    chk_byte("byte16 readback", 8'hc3, d);
    $display("test regs done");
  endtask

  // enable one channel, check its nibble, then disable it again
  task automatic cas_ch(input logic [4:0] s, input logic [7:0] ea,
                        input logic [7:0] ev, input logic [7:0] ba,
                        input logic [7:0] bv, input logic [3:0] sig);
    wr(ea, ev);
    wr(ba, bv);
    boundary();
    tick();
    chan(s, 1'b1, sig);
    wr(ea, 8'h00);
    tick();
    chan(s, 1'b0, 4'h0);
  endtask

  task automatic t_cas();
    mode = TSR_E1_CAS;
    cas_ch(5'd0, 8'h08, 8'h02, 8'h51, 8'h9c, 4'hc);
    cas_ch(5'd7, 8'h09, 8'h01, 8'h54, 8'hd0, 4'hd);
    cas_ch(5'd15, 8'h0a, 8'h02, 8'h58, 8'h6e, 4'h6);
    cas_ch(5'd29, 8'h0b, 8'h80, 8'h5f, 8'hb1, 4'hb);
    chan(5'd30, 1'b0, 4'h0);
    // align word sourced from byte 1, each half by its own flag
    wr(`TSR_OFS_SIG_FIRST, 8'h5b);
    wr(`TSR_OFS_EN1, 8'h01);
    boundary();
    repeat (2) tick();
    chk_bit("upper flag", 1'b1, cas_out.upper_cas_align_source);
    chk_byte("upper", 8'h05, {4'h0, cas_out.upper});
    chk_bit("lower flag", 1'b0, cas_out.lower_cas_align_source);
    wr(`TSR_OFS_EN1, 8'h00);
    wr(`TSR_OFS_EN3, 8'h01);
    boundary();
    repeat (2) tick();
    chk_byte("lower", 8'h0b, {4'h0, cas_out.lower});
    chk_bit("upper off", 1'b0, cas_out.upper_cas_align_source);
    wr(`TSR_OFS_EN3, 8'h00);
    $display("test e1 cas done");
  endtask

  task automatic t_esf();
    mode = TSR_T1_ESF;
    wr(`TSR_OFS_EN1, 8'h03);
    wr(`TSR_OFS_EN3, 8'h80);
    wr(`TSR_OFS_SIG_FIRST, 8'h3c);
    wr(`TSR_OFS_SIG_T1END, 8'h7e);
    boundary();
    tick();
    chan(5'd0, 1'b1, 4'hc);
    chan(5'd1, 1'b1, 4'h3);
    chan(5'd23, 1'b1, 4'h7);
    chan(5'd24, 1'b0, 4'h0);
    $display("test t1 esf done");
  endtask

  task automatic t_d4();
    do_reset();
    mode = TSR_T1_D4;
    wr(`TSR_OFS_EN1, 8'h01);
    wr(`TSR_OFS_SIG_FIRST, 8'h06);
    boundary();
    chk_bit("window open", 1'b1, d4_write_window);
    chan(5'd0, 1'b1, 4'h4);
    chk_bit("use_cd low", 1'b0, d4_use_cd);
    wr(`TSR_OFS_SIG_FIRST, 8'h0f);
    boundary();
    tick();
    chan(5'd0, 1'b1, 4'h8);
    chk_bit("use_cd high", 1'b1, d4_use_cd);
    repeat (WIN) tick();
    chk_bit("window shut", 1'b0, d4_write_window);
    boundary();
    tick();
    chan(5'd0, 1'b1, 4'hc);
    $display("test t1 d4 done");
  endtask

  task automatic t_ccs();
    mode = TSR_E1_CCS;
    wr(`TSR_OFS_SIG_FIRST, 8'h80);
    wr(`TSR_OFS_SIG_LAST, 8'h01);
    boundary();
    repeat (2) tick();
    chk_bit("ccs bit 1", 1'b1, ccs_bit);
    ccs_shift = 1'b1;
    tick();
    ccs_shift = 1'b0;
    repeat (2) tick();
    chk_bit("ccs bit 2", 1'b0, ccs_bit);
    ccs_shift = 1'b1;
    repeat (126) tick();
    ccs_shift = 1'b0;
    repeat (2) tick();
    chk_bit("ccs bit 128", 1'b1, ccs_bit);
    chan(5'd0, 1'b0, 4'h0);
    $display("test e1 ccs done");
  endtask

  // ==========================================================
  // verdict
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    bad_count = 0; n_tests = 0;
    srst = 1'b1; host = '0; mode = TSR_E1_CAS;
    mf_boundary = 1'b0; ch_sel = 5'd0; ccs_shift = 1'b0;
    t_regs();
    t_cas();
    t_esf();
    t_d4();
    t_ccs();
    close_out();
  end

  // hang guard: the whole run is far shorter than this
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule

`default_nettype wire
